// ===== pkg/rx_link_pkg.sv
// Constants, register map and symbol codes for the serial lane receiver.
// Assumes a 40 MHz core clock; rates in kbit/s.
package rx_link_pkg;

  // Register offsets on the documented register port
  localparam logic [11:0] ADDR_LINK_MODE = 12'h0110;
  localparam logic [11:0] ADDR_INTERP = 12'h0111;
  localparam logic [11:0] ADDR_SER_POWER = 12'h0200;
  localparam logic [11:0] ADDR_LANE_PD = 12'h0201;
  localparam logic [11:0] ADDR_BOOST_LO = 12'h0240;
  localparam logic [11:0] ADDR_BOOST_HI = 12'h0241;
  localparam logic [11:0] ADDR_GAIN_LO = 12'h0242;
  localparam logic [11:0] ADDR_GAIN_HI = 12'h0243;
  localparam logic [11:0] ADDR_FB_FIRST = 12'h0244;
  localparam logic [11:0] ADDR_FB_LAST = 12'h024b;
  localparam logic [11:0] ADDR_PLL_STATUS = 12'h0281;

  // Field positions
  localparam int PWR_DOWN_BIT = 0;
  localparam int PLL_LOCK_BIT = 0;
  localparam int FB_WIDTH = 5;
  localparam int EQ2_WIDTH = 2;

  // Values after reset
  localparam logic [7:0] RST_SER_POWER = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Ten-bit control symbols, both disparities
  localparam logic [9:0] SYM_K_NEG = 10'h0fa;
  localparam logic [9:0] SYM_K_POS = 10'h305;
  localparam logic [9:0] SYM_A_NEG = 10'h0f3;
  localparam logic [9:0] SYM_A_POS = 10'h30c;
  localparam logic [9:0] SYM_R_NEG = 10'h0f4;
  localparam logic [9:0] SYM_R_POS = 10'h30b;

  // Four ten-bit symbols per word
  localparam int SYM_BITS = 10;
  localparam int SYMS_PER_WORD = 4;
  localparam int WORD_BITS = 40;

  // Counts
  localparam logic [2:0] LOSS_WORDS = 3'h4;
  localparam int PLL_REF_DIV = 4;
  localparam longint LANE_RATE_MIN_KBPS = 64'd3000000;
  localparam longint LANE_RATE_MAX_KBPS = 64'd15000000;

  // Link state
  typedef enum logic [1:0] {ST_CGS, ST_ILAS, ST_DATA} link_state_t;

  // Sample data rate from DAC rate and total interpolation
  function automatic longint data_rate(longint dac, longint interp);
    return dac / interp;
  endfunction

  // Lane rate = (M/L) * NP * 10/8 * data rate
  function automatic longint lane_rate(longint data, longint m, longint l,
                                       longint np);
    return (m * np * 10 * data) / (l * 8);
  endfunction

  // Octet rate: ten line bits per octet
  function automatic longint octet_rate(longint lane);
    return lane / 10;
  endfunction

  // Processing clock: four octets per cycle
  function automatic longint pclk_rate(longint octet);
    return octet / SYMS_PER_WORD;
  endfunction

  // Frame rate from octets per frame
  function automatic longint frame_rate(longint octet, longint f);
    return octet / f;
  endfunction

  // PLL reference: lane rate over 40
  function automatic longint pll_ref_rate(longint lane);
    return lane / WORD_BITS;
  endfunction

endpackage

// ===== hw/rx_stream_fifo.sv
// Synchronous FIFO after the lane deskew buffers.
// Assumes one clock; valid/ready on both sides.
`timescale 1ns/1ps
module rx_stream_fifo #(
  parameter int WIDTH = 320,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW:0] wr_ptr;  // Write pointer with wrap bit
  logic [AW:0] rd_ptr;  // Read pointer with wrap bit
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) &&
              (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);

  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr[AW-1:0]];

  // Pointer update
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Data storage
  always_ff @(posedge clk_in) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data_in;
  end
endmodule

// ===== hw/serial_lane_receiver_link_sync.sv
// Receive-side lane control, code group sync and ILAS deskew, eight lanes.
// Assumes deserialized 40-bit words per lane each clock, LMFC edge pulses
// and a lock flag from the analog lane PLL, all synchronous to core_clk_in.
//
// Functional notes
// - Eight lanes, each a 40-bit parallel word
// - Interface stays off until power bit cleared
// - Mask bit set powers that lane off
// - Data rate and lane rate formulas
// - Octet rate is lane rate over ten
// - Processing clock handles four octets per cycle
// - Frame rate is octet rate over F
// - PLL reference is lane rate over forty
// - PLL reference is DAC clock over four; the divider here counts core_clk_in cycles
// - PLL lock readable as status bit zero
// - Recovery clocked by PLL, phase per lane
// - Boost, gain two bits; feedback five bits
// - Lane FIFOs, one or two links
// - Control characters mark alignment points
// - Release sync at LMFC after four K28.5
// - Align lanes at the A to R transition
// - Elastic buffers release all lanes together
// - ILAS spans four multiframes, second carries R
`timescale 1ns/1ps
module serial_lane_receiver_link_sync #(
  parameter int LANES = 8,
  parameter int EB_DEPTH = 8,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Deserialized lanes
  input wire logic [LANES*40-1:0] serial_lane_input_in,
  input wire logic [LANES-1:0] lane_code_err_in,
  // Link control
  input wire logic dual_link_in,
  input wire logic [1:0] lmfc_edge_in,
  output logic [1:0] link_sync_request_out,
  // Lane PLL and analog controls
  input wire logic serdes_pll_lock_in,
  output logic pll_ref_out,
  output logic [7:0] pll_mode_out,
  output logic [7:0] pll_interp_out,
  output logic [LANES-1:0] lane_enable_out,
  output logic [LANES*2-1:0] eq_boost_out,
  output logic [LANES*2-1:0] eq_gain_out,
  output logic [LANES*5-1:0] eq_feedback_out,
  // Aligned data stream
  output logic stream_valid_out,
  input wire logic stream_ready_in,
  output logic [LANES*40-1:0] stream_data_out
);
  localparam int EA = $clog2(EB_DEPTH);
  localparam int WB = rx_link_pkg::WORD_BITS;
  localparam int SB = rx_link_pkg::SYM_BITS;

  // Elaboration checks
  if (LANES != 8) begin : g_chk_lanes
    $error("lane count must be eight");
  end
  if (EB_DEPTH < 4 || (1 << EA) != EB_DEPTH) begin : g_chk_eb
    $error("elastic depth must be a power of two, at least four");
  end

  // Register file
  logic [7:0] link_mode_select;  // Link mode for PLL dividers
  logic [7:0] interpolation_select;  // Interpolation for PLL dividers
  logic [7:0] serial_interface_power;  // Bit 0 high: interface off
  logic [7:0] lane_power_down_mask;  // Bit per lane, high is off
  logic [7:0] eq_boost_lanes_low;  // Boost, lanes 0..3
  logic [7:0] eq_boost_lanes_high;  // Boost, lanes 4..7
  logic [7:0] eq_gain_lanes_low;  // Gain, lanes 0..3
  logic [7:0] eq_gain_lanes_high;  // Gain, lanes 4..7
  logic [7:0] eq_feedback [LANES];  // Feedback, one per lane
  logic [7:0] lane_pll_status;  // Lock flag

  // Address decode
  wire wr_mode = reg_wr_in && (reg_addr_in == rx_link_pkg::ADDR_LINK_MODE);
  wire wr_interp = reg_wr_in && (reg_addr_in == rx_link_pkg::ADDR_INTERP);
  wire wr_power = reg_wr_in && (reg_addr_in == rx_link_pkg::ADDR_SER_POWER);
  wire wr_pd = reg_wr_in && (reg_addr_in == rx_link_pkg::ADDR_LANE_PD);
  wire wr_blo = reg_wr_in && (reg_addr_in == rx_link_pkg::ADDR_BOOST_LO);
  wire wr_bhi = reg_wr_in && (reg_addr_in == rx_link_pkg::ADDR_BOOST_HI);
  wire wr_glo = reg_wr_in && (reg_addr_in == rx_link_pkg::ADDR_GAIN_LO);
  wire wr_ghi = reg_wr_in && (reg_addr_in == rx_link_pkg::ADDR_GAIN_HI);
  wire in_fb = (reg_addr_in >= rx_link_pkg::ADDR_FB_FIRST) &&
               (reg_addr_in <= rx_link_pkg::ADDR_FB_LAST);
  wire [11:0] fb_off = reg_addr_in - rx_link_pkg::ADDR_FB_FIRST;
  wire [2:0] fb_idx = fb_off[2:0];

  // Interface power and lane enables
  wire iface_on = !serial_interface_power[rx_link_pkg::PWR_DOWN_BIT];
  wire [LANES-1:0] lane_on = {LANES{iface_on}} & ~lane_power_down_mask;

  // Configuration register writes
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link_mode_select <= rx_link_pkg::RST_ZERO;
      interpolation_select <= rx_link_pkg::RST_ZERO;
      serial_interface_power <= rx_link_pkg::RST_SER_POWER;
      lane_power_down_mask <= rx_link_pkg::RST_ZERO;
      eq_boost_lanes_low <= rx_link_pkg::RST_ZERO;
      eq_boost_lanes_high <= rx_link_pkg::RST_ZERO;
      eq_gain_lanes_low <= rx_link_pkg::RST_ZERO;
      eq_gain_lanes_high <= rx_link_pkg::RST_ZERO;
    end else begin
      if (wr_mode) link_mode_select <= reg_wdata_in;
      if (wr_interp) interpolation_select <= reg_wdata_in;
      if (wr_power) serial_interface_power <= reg_wdata_in;
      if (wr_pd) lane_power_down_mask <= reg_wdata_in;
      if (wr_blo) eq_boost_lanes_low <= reg_wdata_in;
      if (wr_bhi) eq_boost_lanes_high <= reg_wdata_in;
      if (wr_glo) eq_gain_lanes_low <= reg_wdata_in;
      if (wr_ghi) eq_gain_lanes_high <= reg_wdata_in;
    end
  end

  // Read-back mux; unmapped offsets read zero
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr_in)
      rx_link_pkg::ADDR_LINK_MODE: next_rdata = link_mode_select;
      rx_link_pkg::ADDR_INTERP: next_rdata = interpolation_select;
      rx_link_pkg::ADDR_SER_POWER: next_rdata = serial_interface_power;
      rx_link_pkg::ADDR_LANE_PD: next_rdata = lane_power_down_mask;
      rx_link_pkg::ADDR_BOOST_LO: next_rdata = eq_boost_lanes_low;
      rx_link_pkg::ADDR_BOOST_HI: next_rdata = eq_boost_lanes_high;
      rx_link_pkg::ADDR_GAIN_LO: next_rdata = eq_gain_lanes_low;
      rx_link_pkg::ADDR_GAIN_HI: next_rdata = eq_gain_lanes_high;
      rx_link_pkg::ADDR_PLL_STATUS: next_rdata = lane_pll_status;
      default: begin
        if (in_fb) next_rdata = eq_feedback[fb_idx];
      end
    endcase
  end

  // Read data register, loaded on a read strobe
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) reg_rdata_out <= 8'h00;
    else if (reg_rd_in) reg_rdata_out <= next_rdata;
  end

  // PLL reference divider, lock status and lane enable outputs
  logic [1:0] ref_div;  // Counts core clock cycles
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ref_div <= 2'h0;
      pll_ref_out <= 1'b0;
      lane_pll_status <= 8'h00;
      lane_enable_out <= '0;
    end else begin
      ref_div <= ref_div + 2'h1;
      pll_ref_out <= ref_div[1];
      lane_pll_status <= {7'h00, serdes_pll_lock_in & iface_on};
      lane_enable_out <= lane_on;
    end
  end

  // Divider selection follows mode and interpolation directly
  assign pll_mode_out = link_mode_select;
  assign pll_interp_out = interpolation_select;
  assign eq_boost_out = {eq_boost_lanes_high, eq_boost_lanes_low};
  assign eq_gain_out = {eq_gain_lanes_high, eq_gain_lanes_low};

  // Per-lane state shared with the link machines
  logic [LANES-1:0] lane_cgs;  // Four K28.5 seen, still in sync
  logic [LANES-1:0] lane_loss;  // One-cycle loss of sync
  logic [LANES-1:0] lane_marked;  // A to R seen during ILAS
  logic [LANES-1:0] lane_ar;  // A to R in this word
  logic [LANES-1:0] lane_nonempty;  // Elastic buffer holds data
  logic [LANES-1:0] lane_restart;  // Owning link restarting
  logic [LANES-1:0] lane_in_ilas;  // Owning link waits for ILAS
  logic [LANES*WB-1:0] eb_head;  // Oldest word of each buffer
  logic [1:0] link_release;  // Link in data phase
  logic [1:0] link_used;  // Link has enabled lanes
  wire rd_go;  // All lanes pop together

  // Lane channels
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    wire [WB-1:0] word = serial_lane_input_in[l*WB +: WB];
    logic [3:0] is_k;
    logic [3:0] is_a;
    logic [3:0] is_r;
    logic prev_a;  // Last symbol of previous word was A
    logic [2:0] err_run;  // Consecutive errored words
    logic [WB-1:0] ebuf [EB_DEPTH];  // Elastic storage
    logic [EA:0] wp;
    logic [EA:0] rp;

    // Control character decode per symbol
    for (genvar s = 0; s < 4; s++) begin : g_sym
      wire [SB-1:0] sym = word[s*SB +: SB];
      assign is_k[s] = (sym == rx_link_pkg::SYM_K_NEG) ||
                       (sym == rx_link_pkg::SYM_K_POS);
      assign is_a[s] = (sym == rx_link_pkg::SYM_A_NEG) ||
                       (sym == rx_link_pkg::SYM_A_POS);
      assign is_r[s] = (sym == rx_link_pkg::SYM_R_NEG) ||
                       (sym == rx_link_pkg::SYM_R_POS);
    end

    // A to R transition, including across the word boundary
    assign lane_ar[l] = (is_r[0] && prev_a) || (is_r[1] && is_a[0]) ||
                        (is_r[2] && is_a[1]) || (is_r[3] && is_a[2]);
    wire all_k = &is_k;
    wire [EA:0] eb_count = wp - rp;
    wire eb_write = lane_on[l] && (lane_marked[l] || (lane_in_ilas[l] &&
                    lane_ar[l]));
    wire eb_over = eb_write && !rd_go &&
                   (eb_count == EB_DEPTH[EA:0]);
    wire err_lost = lane_code_err_in[l] &&
                    (err_run == rx_link_pkg::LOSS_WORDS - 3'h1);
    assign lane_loss[l] = lane_cgs[l] && (err_lost || eb_over);
    assign lane_nonempty[l] = (wp != rp);
    assign eb_head[l*WB +: WB] = lane_on[l] ? ebuf[rp[EA-1:0]] : '0;
    assign eq_feedback_out[l*5 +: 5] =
      eq_feedback[l][rx_link_pkg::FB_WIDTH-1:0];

    // Feedback register for this lane
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) eq_feedback[l] <= rx_link_pkg::RST_ZERO;
      else if (reg_wr_in && in_fb && fb_idx == l) begin
        eq_feedback[l] <= reg_wdata_in;
      end
    end

    // Code group sync and loss detection
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        lane_cgs[l] <= 1'b0;
        err_run <= 3'h0;
        prev_a <= 1'b0;
      end else begin
        prev_a <= is_a[3];
        if (!lane_on[l] || lane_loss[l] || (lane_restart[l] && !all_k)) begin
          lane_cgs[l] <= 1'b0;
          err_run <= 3'h0;
        end else begin
          if (all_k) lane_cgs[l] <= 1'b1;
          err_run <= lane_code_err_in[l] ? err_run + 3'h1 : 3'h0;
        end
      end
    end

    // Elastic buffer pointers and alignment mark
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        lane_marked[l] <= 1'b0;
        wp <= '0;
        rp <= '0;
      end else if (!lane_on[l] || lane_restart[l]) begin
        lane_marked[l] <= 1'b0;
        wp <= '0;
        rp <= '0;
      end else begin
        if (lane_in_ilas[l] && lane_ar[l]) lane_marked[l] <= 1'b1;
        if (eb_write) wp <= wp + 1'b1;
        if (rd_go) rp <= rp + 1'b1;
      end
    end

    // Elastic storage, held until every lane is marked
    always_ff @(posedge core_clk_in) begin
      if (eb_write) ebuf[wp[EA-1:0]] <= word;
    end
  end

  // Link machines: one link over all lanes or two over halves
  for (genvar k = 0; k < 2; k++) begin : g_link
    wire [LANES-1:0] half = (k == 0) ? 8'h0f : 8'hf0;
    wire [LANES-1:0] own = (dual_link_in ? half :
                           ((k == 0) ? 8'hff : 8'h00)) & lane_on;
    wire all_cgs = &(lane_cgs | ~own);
    wire any_loss = |(lane_loss & own);
    wire all_marked = &(lane_marked | ~own);
    rx_link_pkg::link_state_t state;
    rx_link_pkg::link_state_t next_state;

    assign link_used[k] = |own;
    assign link_release[k] = (state == rx_link_pkg::ST_DATA);

    // Next state
    always_comb begin
      next_state = state;
      case (state)
        rx_link_pkg::ST_CGS: begin
          if (link_used[k] && all_cgs && lmfc_edge_in[k]) begin
            next_state = rx_link_pkg::ST_ILAS;
          end
        end
        rx_link_pkg::ST_ILAS: begin
          // Mark comes at the second multiframe start
          if (all_marked) next_state = rx_link_pkg::ST_DATA;
        end
        rx_link_pkg::ST_DATA: next_state = rx_link_pkg::ST_DATA;
        default: next_state = rx_link_pkg::ST_CGS;
      endcase
      if (!link_used[k] || any_loss) begin
        next_state = rx_link_pkg::ST_CGS;
      end
    end

    // State register and sync request output, low from reset
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        state <= rx_link_pkg::ST_CGS;
        link_sync_request_out[k] <= 1'b0;
      end else begin
        state <= next_state;
        link_sync_request_out[k] <=
          (next_state != rx_link_pkg::ST_CGS);
      end
    end
  end

  // Lane ownership of restart and ILAS wait
  for (genvar l = 0; l < LANES; l++) begin : g_own
    wire lk = dual_link_in && (l >= LANES / 2);
    assign lane_restart[l] = lk ? (g_link[1].state == rx_link_pkg::ST_CGS) :
                             (g_link[0].state == rx_link_pkg::ST_CGS);
    assign lane_in_ilas[l] = lk ? (g_link[1].state == rx_link_pkg::ST_ILAS) :
                             (g_link[0].state == rx_link_pkg::ST_ILAS);
  end

  // Pop when every used link streams and every enabled lane holds data
  wire links_ok = |link_used && &(link_release | ~link_used);
  wire fifo_ready;
  assign rd_go = links_ok && &(lane_nonempty | ~lane_on) && fifo_ready;

  // Aligned words into the stream FIFO, four octets per lane per clock
  rx_stream_fifo #(
    .WIDTH(LANES * WB),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(rd_go),
    .in_ready_out(fifo_ready),
    .in_data_in(eb_head),
    .out_valid_out(stream_valid_out),
    .out_ready_in(stream_ready_in),
    .out_data_out(stream_data_out)
  );
endmodule

// ===== testbench/rx_link_checker.sv
// Concurrent checks on the receiver ports.
// Bound into the receiver top.
`timescale 1ns/1ps
module rx_link_checker #(
  parameter int LANES = 8
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Link and lanes
  input wire logic [LANES-1:0] lane_code_err_in,
  input wire logic [1:0] lmfc_edge_in,
  input wire logic [1:0] link_sync_request_out,
  input wire logic serdes_pll_lock_in,
  input wire logic pll_ref_out,
  input wire logic [LANES-1:0] lane_enable_out,
  input wire logic [LANES*5-1:0] eq_feedback_out,
  // Stream
  input wire logic stream_valid_out,
  input wire logic stream_ready_in,
  input wire logic [LANES*40-1:0] stream_data_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_off_no_sync;
    (lane_enable_out == '0)[*2] |-> link_sync_request_out == 2'b00;
  endproperty
  a_off_no_sync: assert property (p_off_no_sync)
    else $error("sync with no lane");
  property p_sync0_lmfc;
    $rose(link_sync_request_out[0]) |-> $past(lmfc_edge_in[0]);
  endproperty
  a_sync0_lmfc: assert property (p_sync0_lmfc)
    else $error("sync0 off LMFC");
  property p_sync1_lmfc;
    $rose(link_sync_request_out[1]) |-> $past(lmfc_edge_in[1]);
  endproperty
  a_sync1_lmfc: assert property (p_sync1_lmfc)
    else $error("sync1 off LMFC");
  property p_loss;
    (lane_enable_out[3] && lane_code_err_in[3])[*4]
      |-> ##[1:2] !link_sync_request_out[0];
  endproperty
  a_loss: assert property (p_loss)
    else $error("sync kept on loss");
  property p_power_off;
    reg_wr_in && reg_addr_in == rx_link_pkg::ADDR_SER_POWER
      && reg_wdata_in[0] |-> ##2 lane_enable_out == '0;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("lanes on, iface off");
  property p_mask;
    reg_wr_in && reg_addr_in == rx_link_pkg::ADDR_LANE_PD
      |-> ##2 (lane_enable_out & $past(reg_wdata_in, 2)) == '0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked lane on");
  property p_feedback;
    reg_wr_in && reg_addr_in == rx_link_pkg::ADDR_FB_FIRST
      |=> eq_feedback_out[4:0] == $past(reg_wdata_in[4:0]);
  endproperty
  a_feedback: assert property (p_feedback)
    else $error("feedback mismatch");
  property p_ref_div;
    $rose(pll_ref_out) |-> ##4 $rose(pll_ref_out);
  endproperty
  a_ref_div: assert property (p_ref_div)
    else $error("ref not clk/4");
  property p_lock_low;
    reg_rd_in && reg_addr_in == rx_link_pkg::ADDR_PLL_STATUS
      && !serdes_pll_lock_in && !$past(serdes_pll_lock_in)
      |=> reg_rdata_out == 8'h00;
  endproperty
  a_lock_low: assert property (p_lock_low)
    else $error("lock read high");
  property p_hold;
    stream_valid_out && !stream_ready_in
      |=> stream_valid_out && $stable(stream_data_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stream not held");
endmodule
bind serial_lane_receiver_link_sync rx_link_checker #(.LANES(LANES))
  u_rx_link_checker (.*);

// ===== testbench/tx_link_model.sv
// Transmitter model: K words, four-multiframe ILAS, counting data.
// Assumes eight-word multiframes; lane l lags by l mod 3 words.
`timescale 1ns/1ps
module tx_link_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Sync and fault commands
  input wire logic sync_req_in,
  input wire logic [7:0] err_cmd_in,
  // Lane side
  output logic [319:0] lanes_out,
  output logic [7:0] code_err_out,
  output logic [1:0] lmfc_out
);
  logic [2:0] mf_cnt; // Slot within multiframe
  logic [1:0] phase; // 0 K words, 1 wait LMFC, 2 ILAS and data
  logic [7:0] seq; // Word count since ILAS start
  logic [39:0] dly [0:2]; // Skew delay line
  logic [39:0] next_word;
  // Word content per phase
  always_comb begin
    next_word = {4{2'b01, seq}};
    if (phase != 2'd2) begin
      next_word = {4{rx_link_pkg::SYM_K_NEG}};
    end else if (seq < 8'd32 && seq[2:0] == 3'd7) begin
      next_word[39:30] = rx_link_pkg::SYM_A_NEG;
    end else if (seq == 8'd8) begin
      next_word[9:0] = rx_link_pkg::SYM_R_NEG;
    end
  end
  // Phase, LMFC and delay line
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mf_cnt <= 3'd0;
      phase <= 2'd0;
      seq <= 8'h00;
      lmfc_out <= 2'b00;
      dly <= '{default: '0};
    end else begin
      mf_cnt <= mf_cnt + 3'd1;
      lmfc_out <= {2{mf_cnt == 3'd7}};
      seq <= seq + 8'h01;
      dly[0] <= next_word;
      dly[1] <= dly[0];
      dly[2] <= dly[1];
      if (!sync_req_in) begin
        phase <= 2'd0;
      end else if (phase == 2'd0) begin
        phase <= 2'd1;
      end else if (phase == 2'd1 && mf_cnt == 3'd7) begin
        phase <= 2'd2;
        seq <= 8'h00;
      end
    end
  end
  // Lanes, zeroed on fault
  for (genvar l = 0; l < 8; l++) begin : g_lane
    assign lanes_out[l*40+:40] = err_cmd_in[l] ? 40'h0 : dly[l%3];
  end
  assign code_err_out = err_cmd_in;
endmodule

// ===== testbench/tb_top.sv
// Testbench: registers, sync, deskew, stall, loss, dual link.
// Assumes the transmitter model drives lanes and LMFC pulses.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] addr = 12'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, mode, interp, lane_en, errc = 8'h00, cerr;
  logic dual = 1'b0;
  logic lock = 1'b1;
  logic sr = 1'b1;
  logic sv, pref;
  logic [1:0] lmfc, sync;
  logic [15:0] boost, gain;
  logic [39:0] fb;
  logic [319:0] lanes, sd;
  int err_count = 0;
  int total_checks = 0;
  always #12.5 clk = ~clk;
  serial_lane_receiver_link_sync u_serial_lane_receiver_link_sync (
    .core_clk_in(clk), .arst_n_in(arst_n), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .serial_lane_input_in(lanes),
    .lane_code_err_in(cerr), .dual_link_in(dual), .lmfc_edge_in(lmfc),
    .link_sync_request_out(sync), .serdes_pll_lock_in(lock),
    .pll_ref_out(pref), .pll_mode_out(mode), .pll_interp_out(interp),
    .lane_enable_out(lane_en), .eq_boost_out(boost), .eq_gain_out(gain),
    .eq_feedback_out(fb), .stream_valid_out(sv),
    .stream_ready_in(sr), .stream_data_out(sd));
  tx_link_model u_tx_link_model (.clk_in(clk), .arst_n_in(arst_n),
    .sync_req_in(sync[0]), .err_cmd_in(errc), .lanes_out(lanes),
    .code_err_out(cerr), .lmfc_out(lmfc));
  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [39:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_sync(input logic [1:0] m);
    int n = 0;
    while ((sync & m) !== m) begin
      @(negedge clk);
      if (++n > 600) begin
        err_count++;
        close_out();
      end
    end
  endtask
  // Reset values and unmapped read
  task automatic t_reset_values;
    logic [7:0] d;
    check(sync, 2'b00);
    reg_read(rx_link_pkg::ADDR_SER_POWER, d);
    check(d, 8'h01);
    for (int a = 12'h240; a <= 12'h24b; a++) begin
      reg_read(a[11:0], d);
      check(d, 8'h00);
    end
    reg_read(12'h0300, d);
    check(d, 8'h00);
    reg_read(rx_link_pkg::ADDR_PLL_STATUS, d);
    check(d, 8'h00);
  endtask
  // Register effects
  task automatic t_config;
    logic [7:0] d;
    reg_write(rx_link_pkg::ADDR_LINK_MODE, 8'h0b);
    reg_write(rx_link_pkg::ADDR_INTERP, 8'h08);
    reg_write(rx_link_pkg::ADDR_BOOST_LO, 8'haa);
    reg_write(rx_link_pkg::ADDR_BOOST_HI, 8'hff);
    reg_write(rx_link_pkg::ADDR_GAIN_LO, 8'h55);
    reg_write(rx_link_pkg::ADDR_GAIN_HI, 8'hff);
    for (int l = 0; l < 8; l++)
      reg_write(rx_link_pkg::ADDR_FB_FIRST + l[11:0], 8'h18 + l[7:0]);
    #1 check({mode, interp}, 16'h0b08);
    check({boost, gain}, 32'hffaa_ff55);
    for (int l = 0; l < 8; l++)
      check(fb[l*5+:5], 5'h18 + l[4:0]);
    reg_write(rx_link_pkg::ADDR_SER_POWER, 8'h00);
    reg_write(rx_link_pkg::ADDR_LANE_PD, 8'h81);
    @(posedge clk);
    #1 check(lane_en, 8'h7e);
    reg_write(rx_link_pkg::ADDR_LANE_PD, 8'h00);
    reg_write(rx_link_pkg::ADDR_PLL_STATUS, 8'hfe);
    reg_read(rx_link_pkg::ADDR_PLL_STATUS, d);
    check({lane_en, d}, 16'hff01);
    lock <= 1'b0;
    repeat (2) @(posedge clk);
    reg_read(rx_link_pkg::ADDR_PLL_STATUS, d);
    check(d, 8'h00);
    lock <= 1'b1;
  endtask
  // Sync, aligned stream, stall
  task automatic t_link;
    logic [7:0] exp = 8'h08;
    int pops = 0, n = 0;
    wait_sync(2'b01);
    check(sync[1], 1'b0);
    while (pops < 40 && n < 400) begin
      @(negedge clk);
      n++;
      if (sv && sr) begin
        if (pops == 0) check(sd[9:0], rx_link_pkg::SYM_R_NEG);
        for (int l = 1; l < 8; l++) check(sd[l*40+:40], sd[39:0]);
        check(sd[17:10], exp);
        exp++;
        pops++;
        if (pops == 10) begin
          @(posedge clk);
          sr <= 1'b0;
          repeat (18) @(posedge clk);
          sr <= 1'b1;
        end
      end
    end
    if (pops < 40) err_count++;
  endtask
  // Loss on lane 3, dual link, power off
  task automatic t_loss_dual_off;
    @(posedge clk);
    errc <= 8'h08;
    repeat (4) @(posedge clk);
    errc <= 8'h00;
    repeat (2) @(posedge clk);
    #1 check(sync[0], 1'b0);
    @(posedge clk);
    dual <= 1'b1;
    wait_sync(2'b11);
    check(sync, 2'b11);
    reg_write(rx_link_pkg::ADDR_SER_POWER, 8'h01);
    repeat (3) @(posedge clk);
    #1 check({sync, lane_en}, 10'h000);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset_values();
    t_config();
    t_link();
    t_loss_dual_off();
    close_out();
  end
endmodule
